// ==== inc/ple_pkg.sv ====
package ple_pkg;
  // Sizing of the equation array and the external signal list
  localparam int NUM_TERMS = 8;
  localparam int NUM_EXT = 32;
  localparam int NUM_SIG = NUM_EXT + 3 * NUM_TERMS;
  localparam int SEL_W = 6;
  localparam int TIME_W = 16;
  localparam int TERM_W = 3;
  localparam logic [TERM_W-1:0] LAST_TERM = 3'h7;

  // Register map, one aligned word each; equation k at base + 16*k
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_OUT = 12'h008;
  localparam logic [11:0] TERM_BASE = 12'h100;
  localparam int TERM_STRIDE_SH = 4;
  localparam logic [1:0] W_SEL = 2'h0;
  localparam logic [1:0] W_CFG = 2'h1;
  localparam logic [1:0] W_TIME = 2'h2;
  localparam logic [1:0] W_STATE = 2'h3;

  // Field positions of the select word
  localparam int SEL_IN0_LSB = 0;
  localparam int SEL_STRIDE = 8;
  // Field positions of the config word
  localparam int CFG_INV_LSB = 0;
  localparam int CFG_USE_LSB = 4;
  localparam int CFG_GATE_LSB = 8;
  localparam int CFG_RSEL_LSB = 16;
  localparam int CFG_RINV_BIT = 24;
  localparam int CTRL_RUN_BIT = 0;

  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  typedef enum logic [1:0] {
    PLE_AND,
    PLE_OR,
    PLE_NAND,
    PLE_NOR
  } ple_gate_t;

  typedef struct packed {
    logic [TIME_W-1:0] rise_delay_time;
    logic [TIME_W-1:0] fall_delay_time;
  } ple_time_t;

  typedef struct packed {
    logic latched_n;
    logic latched;
    logic direct;
  } ple_out_t;
endpackage

// ==== logic/ple_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ple_top
  import ple_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Assignable signals from outside the clock domain
  input wire logic [ple_pkg::NUM_EXT-1:0] ext_sig,
  // Equation results
  output logic [ple_pkg::NUM_TERMS-1:0] term_direct,
  output logic [ple_pkg::NUM_TERMS-1:0] term_latched,
  output logic [ple_pkg::NUM_TERMS-1:0] term_latched_n,
  output logic pass_done
);
  import ple_pkg::*;

  // ==========================================================
  // Input synchroniser
  logic [NUM_EXT-1:0] ext_s1_q;
  logic [NUM_EXT-1:0] ext_s2_q;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
    end
    else
    begin
      ext_s1_q <= ext_sig;
      ext_s2_q <= ext_s1_q;
    end

  // ==========================================================
  // Configuration storage
  logic [31:0] sel_q [NUM_TERMS];
  logic [31:0] cfg_q [NUM_TERMS];
  ple_time_t tim_q [NUM_TERMS];
  logic [31:0] ctrl_q;
  logic [3:0] in_st_q [NUM_TERMS];
  logic [TIME_W-1:0] cnt_q [NUM_TERMS];
  logic [TERM_W-1:0] idx_q;
  logic [NUM_TERMS-1:0] dir_q;
  logic [NUM_TERMS-1:0] lat_q;
  logic [NUM_TERMS-1:0] latn_q;
  logic [NUM_TERMS-1:0] gate_q;
  logic done_q;
  logic [31:0] rdata_q;

  // APB decode; zero wait states
  wire bus_wr = psel && penable && pwrite;
  wire bus_rd = psel && !penable && !pwrite;
  wire in_term = paddr[11:8] == TERM_BASE[11:8];
  wire [TERM_W-1:0] a_term = paddr[TERM_STRIDE_SH+TERM_W-1:TERM_STRIDE_SH];
  wire [1:0] a_word = paddr[3:2];
  wire a_hole = in_term && (paddr[7:TERM_STRIDE_SH+TERM_W] != '0);
  wire a_known = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
    (paddr == ADDR_OUT) || (in_term && !a_hole && paddr[1:0] == 2'h0);
  wire run = ctrl_q[CTRL_RUN_BIT];

  // ==========================================================
  // Signal list: external, then direct, latched, latched_n per term
  wire [NUM_SIG-1:0] sig_list = {latn_q, lat_q, dir_q, ext_s2_q};

  function automatic logic pick(input logic [NUM_SIG-1:0] l,
                                input logic [SEL_W-1:0] s);
    logic r;
    r = 1'b0;
    if (int'(s) < NUM_SIG)
      r = l[s];
    return r;
  endfunction

  // Current term: reading live dir/lat makes terms below idx
  // already updated this pass and terms above still from last pass
  wire [31:0] c_sel = sel_q[idx_q];
  wire [31:0] c_cfg = cfg_q[idx_q];
  ple_time_t c_tim;
  assign c_tim = tim_q[idx_q];
  wire [3:0] c_inv = c_cfg[CFG_INV_LSB+:4];
  wire [3:0] c_use = c_cfg[CFG_USE_LSB+:4];
  wire [1:0] c_gate = c_cfg[CFG_GATE_LSB+:2];
  wire [3:0] c_in;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_in
      assign c_in[gi] = pick(sig_list,
        c_sel[SEL_IN0_LSB+gi*SEL_STRIDE+:SEL_W]) ^ c_inv[gi];
    end
  endgenerate
  // Unused inputs read as the neutral value of each gate
  wire and_v = &(c_in | ~c_use);
  wire or_v = |(c_in & c_use);
  wire has_use = |c_use;
  logic gate_v;
  always_comb
  begin
    case (ple_gate_t'(c_gate))
      PLE_AND: gate_v = has_use && and_v;
      PLE_OR: gate_v = or_v;
      PLE_NAND: gate_v = !(has_use && and_v);
      PLE_NOR: gate_v = !or_v;
      default: gate_v = 1'b0;
    endcase
  end

  // Timer: a count of passes the gate has differed from the output
  wire c_dir = dir_q[idx_q];
  wire [TIME_W-1:0] c_cnt = cnt_q[idx_q];
  wire [TIME_W-1:0] c_lim = c_dir ? c_tim.fall_delay_time :
    c_tim.rise_delay_time;
  wire differ = gate_v != c_dir;
  wire expire = differ && (c_cnt + 1'b1 >= c_lim || c_lim == '0);
  wire dir_d = expire ? gate_v : c_dir;
  wire [TIME_W-1:0] cnt_d = (differ && !expire) ? c_cnt + 1'b1 : '0;

  // Latch, reset dominant
  wire rst_v = pick(sig_list, c_cfg[CFG_RSEL_LSB+:SEL_W]) ^
    c_cfg[CFG_RINV_BIT];
  wire lat_d = rst_v ? 1'b0 : (lat_q[idx_q] | dir_d);

  // ==========================================================
  // Sequential evaluation, one term per clock
  wire last = idx_q == LAST_TERM;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      idx_q <= '0;
      dir_q <= '0;
      lat_q <= '0;
      latn_q <= '1;
      gate_q <= '0;
      done_q <= 1'b0;
      for (int i = 0; i < NUM_TERMS; i++)
      begin
        cnt_q[i] <= '0;
        in_st_q[i] <= '0;
      end
    end
    else if (run)
    begin
      idx_q <= last ? '0 : idx_q + 1'b1;
      dir_q[idx_q] <= dir_d;
      lat_q[idx_q] <= lat_d;
      latn_q[idx_q] <= !lat_d;
      gate_q[idx_q] <= gate_v;
      cnt_q[idx_q] <= cnt_d;
      in_st_q[idx_q] <= c_in;
      done_q <= last;
    end
    else
      done_q <= 1'b0;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      ctrl_q <= CTRL_RESET;
      for (int i = 0; i < NUM_TERMS; i++)
      begin
        sel_q[i] <= SEL_RESET;
        cfg_q[i] <= CFG_RESET;
        tim_q[i] <= TIME_RESET;
      end
    end
    // Misaligned or unmapped writes are dropped, in step with pslverr
    else if (bus_wr && a_known)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_q <= pwdata & 32'h0000_0001;
      else if (in_term && !a_hole && a_word == W_SEL)
        sel_q[a_term] <= pwdata;
      else if (in_term && !a_hole && a_word == W_CFG)
        // Keep inv, use, gate, reset select and reset invert only
        cfg_q[a_term] <= pwdata & 32'h013F_03FF;
      else if (in_term && !a_hole && a_word == W_TIME)
        tim_q[a_term] <= pwdata;
    end

  // Read mux, captured in setup so prdata is registered
  wire [31:0] st_word = {24'h00_0000, gate_q[a_term], lat_q[a_term],
    latn_q[a_term], dir_q[a_term], in_st_q[a_term]};
  logic [31:0] rd_v;
  always_comb
  begin
    rd_v = 32'h0000_0000;
    if (paddr == ADDR_CTRL)
      rd_v = ctrl_q;
    else if (paddr == ADDR_STATUS)
      rd_v = {29'h0, idx_q};
    else if (paddr == ADDR_OUT)
      rd_v = {8'h00, latn_q, lat_q, dir_q};
    else if (in_term && !a_hole)
    begin
      case (a_word)
        W_SEL: rd_v = sel_q[a_term];
        W_CFG: rd_v = cfg_q[a_term];
        W_TIME: rd_v = tim_q[a_term];
        W_STATE: rd_v = st_word;
        default: rd_v = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      rdata_q <= '0;
    else if (bus_rd)
      rdata_q <= rd_v;

  // Error flag registered at setup too, so pslverr is a flop
  logic err_q;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      err_q <= 1'b0;
    else if (psel && !penable)
      err_q <= !a_known;

  // ==========================================================
  // Outputs
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = err_q;
  assign term_direct = dir_q;
  assign term_latched = lat_q;
  // Complement kept in its own flop so every term output leaves a register
  assign term_latched_n = latn_q;
  assign pass_done = done_q;

  // ==========================================================
  // Checks
  a_reset_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && rst_v |=> !lat_q[$past(idx_q)])
    else $error("latch not cleared by reset");
  a_idx_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && last |=> idx_q == '0)
    else $error("index did not wrap");
  a_zero_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && c_lim == '0 |=> dir_q[$past(idx_q)] == $past(gate_v))
    else $error("zero delay did not pass");
  a_hold_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && differ && c_lim > 16'h0001 && c_cnt == '0
    |=> dir_q[$past(idx_q)] == $past(c_dir))
    else $error("output moved before delay");
  a_latch_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && dir_d && !rst_v |=> lat_q[$past(idx_q)])
    else $error("latch not set");
  a_comp_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    term_latched_n == ~term_latched)
    else $error("complement mismatch");
  a_or_neutral: assert property (@(posedge clk_sys) disable iff (!resetn)
    c_gate == 2'h1 && c_use == 4'h0 |-> !gate_v)
    else $error("unused inputs affected gate");
  a_done_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    pass_done |=> !pass_done)
    else $error("pass_done not a pulse");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && !rst_v && lat_q[idx_q] |=> lat_q[$past(idx_q)])
    else $error("latch dropped without reset");
  a_cnt_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && !differ |=> cnt_q[$past(idx_q)] == '0)
    else $error("delay count not cleared");
  a_idx_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    run && !last |=> idx_q == $past(idx_q) + 1'b1)
    else $error("index skipped a term");
  a_and_neutral: assert property (@(posedge clk_sys) disable iff (!resetn)
    c_gate == 2'h0 && c_use == 4'h0 |-> !gate_v)
    else $error("empty and gate not low");
  a_state_in: assert property (@(posedge clk_sys) disable iff (!resetn)
    run |=> in_st_q[$past(idx_q)] == $past(c_in))
    else $error("input state not recorded");
  a_rd_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
endmodule
`default_nettype wire

// ==== sim/ple_field.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Field side: protection levels, changed only on clock edges
module ple_field
  import ple_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requested levels and the driven signal list
  input wire logic [ple_pkg::NUM_EXT-1:0] want,
  output logic [ple_pkg::NUM_EXT-1:0] ext_sig
);
  import ple_pkg::*;
  initial ext_sig = '0;
  always @(posedge clk_sys)
    ext_sig <= want;
endmodule
`default_nettype wire

// ==== sim/ple_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ple_top_tb;
  import ple_pkg::*;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, want = '0;
  logic pready, pslverr, pass_done;
  logic [NUM_EXT-1:0] ext_sig;
  logic [NUM_TERMS-1:0] t_dir, t_lat, t_latn;
  logic [32:0] exp_q[$];
  logic [6:0] look_q[$];
  logic [6:0] lk;
  logic [4:0] lt[4] = '{5'b01011, 5'b00010, 5'b11101, 5'b00100};
  int num_errors = 0, total_checks = 0, gap = -1;
  integer seed = 32'h95c2;
  always #10 clk_sys = ~clk_sys;
  ple_top i_ple_top(.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_sig(ext_sig), .term_direct(t_dir), .term_latched(t_lat),
    .term_latched_n(t_latn), .pass_done(pass_done));
  ple_field i_ple_field(.clk_sys(clk_sys), .want(want), .ext_sig(ext_sig));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Read data is taken only at the edge that completes the access
  always @(posedge clk_sys)
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
  // Term levels are looked at on the falling edge, once settled
  always @(negedge clk_sys)
    while (look_q.size() != 0)
    begin
      lk = look_q.pop_front();
      chk({30'h0, t_latn[lk[6:3]], t_lat[lk[6:3]], t_dir[lk[6:3]]},
          {30'h0, lk[2:0]});
    end
  // One pass takes one clock per logic_term
  always @(negedge clk_sys)
    if (pass_done === 1'b1)
    begin
      if (gap >= 0)
        chk(33'(gap), 33'(NUM_TERMS));
      gap = 1;
    end
    else if (gap >= 0)
      gap++;
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    final_report;
  end
  // ==========================================================
  // APB master and helpers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic passes(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      while (pass_done !== 1'b1)
        @(posedge clk_sys);
    end
  endtask
  task automatic pchk(input int k, input logic [2:0] e);
    look_q.push_back({4'(k), e});
  endtask
  function automatic logic [11:0] ta(input int k, input int w);
    return TERM_BASE + 12'(k * 16 + w * 4);
  endfunction
  function automatic logic [31:0] cw(input logic [3:0] inv,
    input logic [3:0] u, input logic [1:0] g, input logic [5:0] rs,
    input logic ri);
    return {7'h0, ri, 2'h0, rs, 6'h0, g, u, inv};
  endfunction
  // ==========================================================
  // Scenarios
  initial
  begin : main
    logic [3:0] v, inv, u, c;
    logic e;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_CTRL, {1'b0, CTRL_RESET});
    rd(ta(1, 1), {1'b0, CFG_RESET});
    rd(12'h0F0, 33'h1_0000_0000);
    apb(1'b1, ta(0, 0), 32'h0302_0100);
    for (int i = 0; i < 8; i++)
    begin
      v = 4'($random(seed));
      inv = 4'($random(seed));
      u = (i < 4) ? 4'hf : 4'($random(seed)) | 4'h1;
      c = v ^ inv;
      case (i % 4)
        0: e = &(c | ~u);
        1: e = |(c & u);
        2: e = ~&(c | ~u);
        default: e = ~|(c & u);
      endcase
      want[3:0] <= v;
      // Reset select 56 reads 0, inverted: latch held clear throughout
      apb(1'b1, ta(0, 1), cw(inv, u, 2'(i), 6'd56, 1'b1));
      passes(3);
      pchk(0, {2'b10, e});
    end
    apb(1'b1, ta(1, 0), 32'h0000_0004);
    apb(1'b1, ta(1, 1), cw(4'h0, 4'h1, 2'd1, 6'd5, 1'b0));
    rd(ta(1, 1), {1'b0, cw(4'h0, 4'h1, 2'd1, 6'd5, 1'b0)});
    for (int i = 0; i < 4; i++)
    begin
      want[5:4] <= lt[i][4:3];
      passes(3);
      pchk(1, lt[i][2:0]);
    end
    apb(1'b1, ta(1, 1), cw(4'h0, 4'h1, 2'd1, 6'd5, 1'b1));
    want[5:4] <= 2'b11;
    passes(3);
    pchk(1, 3'b011);
    want[5:4] <= 2'b01;
    passes(3);
    pchk(1, 3'b101);
    apb(1'b1, ta(2, 0), 32'h0000_0030);
    apb(1'b1, ta(2, 1), cw(4'h0, 4'h1, 2'd1, 6'd56, 1'b1));
    apb(1'b1, ta(0, 0), 32'h0000_0022);
    apb(1'b1, ta(0, 1), cw(4'h0, 4'h1, 2'd1, 6'd56, 1'b1));
    passes(3);
    pchk(2, 3'b101);
    pchk(0, 3'b101);
    apb(1'b1, ta(4, 0), 32'h0000_0007);
    apb(1'b1, ta(4, 1), cw(4'h0, 4'h1, 2'd1, 6'd56, 1'b1));
    apb(1'b1, ta(4, 2), 32'h0003_0002);
    rd(ta(4, 2), {1'b0, 32'h0003_0002});
    want[7] <= 1'b1;
    passes(2);
    pchk(4, 3'b100);
    passes(3);
    pchk(4, 3'b101);
    want[7] <= 1'b0;
    passes(1);
    pchk(4, 3'b101);
    passes(3);
    pchk(4, 3'b100);
    rd(ADDR_OUT, {1'b0, 32'h00FF_0007});
    rd(ta(4, 3), {1'b0, 24'h00_0000, 4'b0010, {3{v[0]}}, 1'b0});
    final_report;
  end
endmodule
`default_nettype wire
